/* File: rtl/bscm_mapper.sv */
// banked sram column mapper: crossbar, arbitration, column mapping,
// shadow write fifo and the four single-ported sram blocks
// assumes requesters hold a request until granted; inputs synchronous
`timescale 1ns/1ps

module bscm_mapper (
    input  wire logic                               mclk_in,
    input  wire logic                               rst_n_in,
    input  wire bscm_pkg::bscm_req_t                req_in
                                          [bscm_pkg::NUM_PORTS],
    input  wire logic [bscm_pkg::NUM_BLOCKS-1:0]    block_extended_width_bit_in,
    output logic      [bscm_pkg::NUM_PORTS-1:0]     grant_out,
    output bscm_pkg::bscm_rsp_t                     rsp_out
                                          [bscm_pkg::NUM_PORTS],
    output logic                                    io_slot_out
);

    localparam int NB = bscm_pkg::NUM_BLOCKS;
    localparam int NC = bscm_pkg::NUM_COLS;
    localparam int NP = bscm_pkg::NUM_PORTS;
    localparam int CW = bscm_pkg::COL_W;
    localparam int RW = bscm_pkg::ROW_W;
    localparam int AW = bscm_pkg::ADDR_W;
    localparam int DW = bscm_pkg::DATA_W;
    localparam int IW = bscm_pkg::COL_IDX_W;
    localparam int TW = bscm_pkg::TRIPLE_W;

    // ========================================================
    // column mapping
    // four 16-bit columns per row; a word of any space lands on columns
    function automatic bscm_pkg::bscm_col_acc_t map_acc(
        input bscm_pkg::bscm_req_t r,
        input logic                wide,
        input logic                ext
    );
        bscm_pkg::bscm_col_acc_t m;
        logic [AW:0]             t;
        logic [TW-1:0]           w48;
        logic [IW-1:0]           c;
        logic [IW:0]             s;
        m   = '0;
        t   = {1'b0, r.addr} + {r.addr, 1'b0};
        w48 = ext ? {r.wdata[bscm_pkg::EXT_W-1:0], bscm_pkg::EXT_PAD}
                  : r.wdata[TW-1:0];
        c   = '0;
        s   = '0;
        unique case (r.space)
            bscm_pkg::SP_SHORT: begin
                c = r.addr[IW-1:0];
                m.en[c]   = 1'b1;
                m.row[c]  = r.addr[AW-1:IW];
                m.data[c] = r.wdata[CW-1:0];
            end
            bscm_pkg::SP_NORMAL: begin
                if (wide) begin
                    for (int j = 0; j < bscm_pkg::TRIPLE_COLS; j++) begin
                        s = {1'b0, t[IW-1:0]} + (IW+1)'(j);
                        c = s[IW-1:0];
                        m.en[c]   = 1'b1;
                        m.row[c]  = s[IW] ? t[RW+IW-1:IW] + 1'b1
                                          : t[RW+IW-1:IW];
                        m.data[c] = w48[TW-1-CW*j -: CW];
                    end
                end else begin
                    c = {r.addr[0], 1'b0};
                    m.en[c]          = 1'b1;
                    m.en[c+1'b1]     = 1'b1;
                    m.row[c]         = r.addr[RW:1];
                    m.row[c+1'b1]    = r.addr[RW:1];
                    m.data[c]        = r.wdata[CW-1:0];
                    m.data[c+1'b1]   = r.wdata[2*CW-1:CW];
                end
            end
            bscm_pkg::SP_LONG: begin
                for (int k = 0; k < NC; k++) begin
                    m.en[k]   = 1'b1;
                    m.row[k]  = r.addr[RW-1:0];
                    m.data[k] = r.wdata[CW*k +: CW];
                end
            end
            default: m = '0;
        endcase
        return m;
    endfunction : map_acc

    // assemble read columns back into the word seen by the bus
    function automatic logic [DW-1:0] pack_rd(
        input bscm_pkg::bscm_req_t           r,
        input logic                          wide,
        input logic                          ext,
        input logic [NC-1:0][CW-1:0]         cd
    );
        logic [AW:0]   t;
        logic [TW-1:0] w48;
        logic [IW-1:0] c;
        logic [IW:0]   s;
        logic [DW-1:0] v;
        t   = {1'b0, r.addr} + {r.addr, 1'b0};
        w48 = '0;
        c   = '0;
        s   = '0;
        v   = '0;
        unique case (r.space)
            bscm_pkg::SP_SHORT: begin
                v = DW'(cd[r.addr[IW-1:0]]);
            end
            bscm_pkg::SP_NORMAL: begin
                if (wide) begin
                    for (int j = 0; j < bscm_pkg::TRIPLE_COLS; j++) begin
                        s = {1'b0, t[IW-1:0]} + (IW+1)'(j);
                        w48[TW-1-CW*j -: CW] = cd[s[IW-1:0]];
                    end
                    // 40-bit data drops the low pad byte
                    v = ext ? DW'(w48[TW-1:bscm_pkg::EXT_LSB])
                            : DW'(w48);
                end else begin
                    c = {r.addr[0], 1'b0};
                    v = DW'({cd[c+1'b1], cd[c]});
                end
            end
            bscm_pkg::SP_LONG: v = cd;
            default: v = '0;
        endcase
        return v;
    endfunction : pack_rd

    // ========================================================
    // state
    // array is not reset: sram content is unknown after power-up
    logic [CW-1:0]            mem_q [NB][NC][bscm_pkg::ROWS];
    bscm_pkg::bscm_col_acc_t  fifo_q [NB][2];
    bscm_pkg::bscm_col_acc_t  fifo_d [NB][2];
    logic [bscm_pkg::CNT_W-1:0] cnt_q [NB];
    logic [bscm_pkg::CNT_W-1:0] cnt_d [NB];
    bscm_pkg::bscm_rsp_t      rsp_q [NP];
    bscm_pkg::bscm_rsp_t      rsp_d [NP];
    logic                     io_phase_q;
    logic                     io_phase_d;

    // ========================================================
    // arbitration and mapping
    logic [NB-1:0]            win_v;
    logic [1:0]               win_p [NB];
    logic [NP-1:0]            grant;
    logic [NP-1:0]            wide;
    logic [NP-1:0]            ext;
    bscm_pkg::bscm_col_acc_t  acc [NP];
    logic [NB-1:0]            blk_rd;
    logic [NB-1:0]            blk_wr;
    logic [NB-1:0]            ret_v;
    bscm_pkg::bscm_col_acc_t  ret_acc [NB];

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            win_v[b] = 1'b0;
            win_p[b] = '0;
            // scan in port order: io a, io b, core data, core program
            for (int p = 0; p < NP; p++) begin
                if (req_in[p].valid && req_in[p].block == b && !win_v[b]
                    && (p >= bscm_pkg::NUM_IO_PORTS || io_phase_q)) begin
                    win_v[b] = 1'b1;
                    win_p[b] = 2'(p);
                end
            end
        end
        for (int p = 0; p < NP; p++) begin
            grant[p] = win_v[req_in[p].block]
                       && win_p[req_in[p].block] == 2'(p);
            ext[p]   = block_extended_width_bit_in[req_in[p].block];
            wide[p]  = req_in[p].space == bscm_pkg::SP_NORMAL
                       && (req_in[p].fetch || ext[p]);
            acc[p]   = map_acc(req_in[p], wide[p],
                               ext[p] && !req_in[p].fetch);
        end
    end

    // ========================================================
    // shadow write fifo and read path
    always_comb begin
        logic [NC-1:0][CW-1:0] cd;
        logic [1:0]            bk;
        cd = '0;
        bk = '0;
        for (int b = 0; b < NB; b++) begin
            fifo_d[b] = fifo_q[b];
            cnt_d[b]  = cnt_q[b];
            blk_rd[b] = win_v[b] && !req_in[win_p[b]].write;
            blk_wr[b] = win_v[b] && req_in[win_p[b]].write;
            ret_v[b]  = !blk_rd[b] && cnt_q[b] != bscm_pkg::CNT_EMPTY;
            ret_acc[b] = fifo_q[b][0];
            if (ret_v[b]) begin
                fifo_d[b][0] = fifo_q[b][1];
                fifo_d[b][1] = '0;
                cnt_d[b]     = cnt_q[b] - 1'b1;
            end
            if (blk_wr[b]) begin
                fifo_d[b][cnt_d[b][0]] = acc[win_p[b]];
                cnt_d[b] = cnt_d[b] + 1'b1;
            end
        end
        for (int p = 0; p < NP; p++) begin
            rsp_d[p].valid = grant[p] && !req_in[p].write;
            rsp_d[p].data  = rsp_q[p].data;
            bk = req_in[p].block;
            for (int c = 0; c < NC; c++) begin
                cd[c] = mem_q[bk][c][acc[p].row[c]];
                // newest pending write to the same column and row wins
                for (int i = 0; i < 2; i++) begin
                    if (2'(i) < cnt_q[bk] && fifo_q[bk][i].en[c]
                        && fifo_q[bk][i].row[c] == acc[p].row[c]) begin
                        cd[c] = fifo_q[bk][i].data[c];
                    end
                end
            end
            if (rsp_d[p].valid) begin
                rsp_d[p].data = pack_rd(req_in[p], wide[p],
                                 ext[p] && !req_in[p].fetch, cd);
            end
        end
        io_phase_d = !io_phase_q;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            io_phase_q <= bscm_pkg::IO_PHASE_RST;
            for (int b = 0; b < NB; b++) begin
                cnt_q[b]     <= bscm_pkg::CNT_EMPTY;
                fifo_q[b][0] <= '0;
                fifo_q[b][1] <= '0;
            end
            for (int p = 0; p < NP; p++) begin
                rsp_q[p] <= '0;
            end
        end else begin
            io_phase_q <= io_phase_d;
            for (int b = 0; b < NB; b++) begin
                cnt_q[b]  <= cnt_d[b];
                fifo_q[b] <= fifo_d[b];
            end
            for (int p = 0; p < NP; p++) begin
                rsp_q[p] <= rsp_d[p];
            end
        end
    end

    // retired fifo heads are the only writers of the arrays
    always_ff @(posedge mclk_in) begin
        for (int b = 0; b < NB; b++) begin
            for (int c = 0; c < NC; c++) begin
                if (ret_v[b] && ret_acc[b].en[c]) begin
                    mem_q[b][c][ret_acc[b].row[c]] <= ret_acc[b].data[c];
                end
            end
        end
    end

    assign grant_out   = grant;
    assign rsp_out     = rsp_q;
    assign io_slot_out = io_phase_q;

    // ========================================================
    // checks
    a_io_half_rate: assert property (@(posedge mclk_in) disable iff
        (!rst_n_in) (grant[bscm_pkg::PORT_IO_A]
        || grant[bscm_pkg::PORT_IO_B]) |-> io_phase_q
        ##1 !io_phase_q) else $error("io grant outside io slot");

    a_core_beats_prog: assert property (@(posedge mclk_in) disable iff
        (!rst_n_in) req_in[bscm_pkg::PORT_CORE_DATA].valid
        && req_in[bscm_pkg::PORT_CORE_PROG].valid
        && req_in[bscm_pkg::PORT_CORE_DATA].block
           == req_in[bscm_pkg::PORT_CORE_PROG].block
        |-> !grant[bscm_pkg::PORT_CORE_PROG])
        else $error("program won over data");

    a_io_beats_core: assert property (@(posedge mclk_in) disable iff
        (!rst_n_in) grant[bscm_pkg::PORT_IO_A]
        && req_in[bscm_pkg::PORT_CORE_DATA].valid
        && req_in[bscm_pkg::PORT_CORE_DATA].block
           == req_in[bscm_pkg::PORT_IO_A].block
        |-> !grant[bscm_pkg::PORT_CORE_DATA])
        else $error("core won over io");

    a_read_gives_rsp: assert property (@(posedge mclk_in) disable iff
        (!rst_n_in) grant[bscm_pkg::PORT_CORE_DATA]
        && !req_in[bscm_pkg::PORT_CORE_DATA].write
        |=> rsp_out[bscm_pkg::PORT_CORE_DATA].valid
        ##1 !rsp_out[bscm_pkg::PORT_CORE_DATA].valid
            || $past(grant[bscm_pkg::PORT_CORE_DATA]))
        else $error("read response missing");

    for (genvar gp = 0; gp < NP; gp++) begin : g_port_chk
        a_short_one_col: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) grant[gp] && req_in[gp].space == bscm_pkg::SP_SHORT
            |-> $onehot(acc[gp].en))
            else $error("short access not one column");
        a_long_all_cols: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) grant[gp] && req_in[gp].space == bscm_pkg::SP_LONG
            |-> &acc[gp].en)
            else $error("long access not four columns");
        a_triple_cols: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) grant[gp] && wide[gp]
            |-> $countones(acc[gp].en) == bscm_pkg::TRIPLE_COLS)
            else $error("wide access not three columns");
    end

    for (genvar gb = 0; gb < NB; gb++) begin : g_blk_chk
        a_one_access: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) $onehot0({grant[0] && req_in[0].block == gb,
            grant[1] && req_in[1].block == gb,
            grant[2] && req_in[2].block == gb,
            grant[3] && req_in[3].block == gb}))
            else $error("two grants on one block");
        a_retire_idle: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) cnt_q[gb] != bscm_pkg::CNT_EMPTY && !win_v[gb]
            |=> cnt_q[gb] == $past(cnt_q[gb]) - 1'b1)
            else $error("fifo did not retire on idle");
        a_read_holds: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) blk_rd[gb] |=> cnt_q[gb] == $past(cnt_q[gb]))
            else $error("fifo moved on a read cycle");
        a_write_queued: assert property (@(posedge mclk_in) disable iff
            (!rst_n_in) blk_wr[gb] && cnt_q[gb] == bscm_pkg::CNT_EMPTY
            |=> cnt_q[gb] == bscm_pkg::CNT_ONE ##1 cnt_q[gb]
                <= bscm_pkg::CNT_FULL)
            else $error("write bypassed fifo");
    end

endmodule : bscm_mapper

/* File: rtl/bscm_pkg.sv */
// package for the banked sram column mapper: sizes, port order, types
// assumes a single core clock; io requesters run at half that rate
package bscm_pkg;

    // ========================================================
    // sizes
    localparam int NUM_BLOCKS   = 4;
    localparam int NUM_COLS     = 4;
    localparam int NUM_PORTS    = 4;
    localparam int NUM_IO_PORTS = 2;
    localparam int TRIPLE_COLS  = 3;
    localparam int COL_W        = 16;
    localparam int ROW_W        = 16;
    localparam int ROWS         = 65536;
    localparam int ADDR_W       = 18;
    localparam int DATA_W       = 64;
    localparam int BLK_W        = 2;
    localparam int COL_IDX_W    = 2;
    localparam int CNT_W        = 2;
    localparam int TRIPLE_W     = 48;
    localparam int EXT_W        = 40;
    localparam int EXT_LSB      = 8;

    // ========================================================
    // port order is also the arbitration order, highest first
    localparam int PORT_IO_A      = 0;
    localparam int PORT_IO_B      = 1;
    localparam int PORT_CORE_DATA = 2;
    localparam int PORT_CORE_PROG = 3;

    // ========================================================
    // reset values and fills
    localparam logic [CNT_W-1:0]   CNT_EMPTY    = 2'h0;
    localparam logic [CNT_W-1:0]   CNT_ONE      = 2'h1;
    localparam logic [CNT_W-1:0]   CNT_FULL     = 2'h2;
    localparam logic               IO_PHASE_RST = 1'h0;
    localparam logic [EXT_LSB-1:0] EXT_PAD      = 8'h00;

    // ========================================================
    // types
    typedef enum logic [2:0] {
        SP_SHORT  = 3'h1,
        SP_NORMAL = 3'h2,
        SP_LONG   = 3'h4
    } bscm_space_t;

    typedef struct packed {
        logic                valid;
        logic                write;
        logic                fetch;
        bscm_space_t         space;
        logic [BLK_W-1:0]    block;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } bscm_req_t;

    typedef struct packed {
        logic                valid;
        logic [DATA_W-1:0]   data;
    } bscm_rsp_t;

    typedef struct packed {
        logic [NUM_COLS-1:0]            en;
        logic [NUM_COLS-1:0][ROW_W-1:0] row;
        logic [NUM_COLS-1:0][COL_W-1:0] data;
    } bscm_col_acc_t;

endpackage : bscm_pkg

/* File: verif/bscm_req_model.sv */
// requester model: one core or io bus master in front of the mapper
// assumes the bench pulses start_in for one cycle with a valid command
`timescale 1ns/1ps

module bscm_req_model (
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   start_in,
    input  wire bscm_pkg::bscm_req_t    cmd_in,
    input  wire logic                   grant_in,
    input  wire bscm_pkg::bscm_rsp_t    rsp_in,
    output bscm_pkg::bscm_req_t         req_out,
    output logic                        busy_out,
    output logic [bscm_pkg::DATA_W-1:0] rdata_out
);
    // ========================================================
    // request held until granted, then released
    logic wait_q;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            req_out <= '0;
            wait_q <= 1'b0;
            rdata_out <= '0;
        end else begin
            if (start_in) begin
                req_out <= cmd_in;
            end else if (req_out.valid && grant_in) begin
                // released fields flip so a stale value never passes
                req_out <= {1'b0, ~req_out[$bits(req_out)-2:0]};
                wait_q <= !req_out.write;
            end
            if (wait_q && rsp_in.valid) begin
                rdata_out <= rsp_in.data;
                wait_q <= 1'b0;
            end
        end
    end

    assign busy_out = req_out.valid | wait_q;
endmodule : bscm_req_model

/* File: verif/testbench.sv */
// testbench for the banked sram column mapper
// assumes one requester model per port; port 2 carries plain traffic
`timescale 1ns/1ps

module testbench;
    // ========================================================
    // signals
    logic                mclk_in;
    logic                rst_n_in;
    logic [3:0]          start;
    logic [3:0]          busy;
    logic [3:0]          block_extended_width_bit_in;
    logic [3:0]          grant_out;
    logic                io_slot_out;
    logic [63:0]         rdata [4];
    bscm_pkg::bscm_req_t cmd [4];
    bscm_pkg::bscm_req_t req_w [4];
    bscm_pkg::bscm_rsp_t rsp_w [4];
    int                  n_mismatch;
    int                  checks;

    bscm_mapper i_bscm_mapper (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .req_in(req_w),
        .block_extended_width_bit_in(block_extended_width_bit_in),
        .grant_out(grant_out),
        .rsp_out(rsp_w),
        .io_slot_out(io_slot_out)
    );

    for (genvar g = 0; g < 4; g++) begin : g_req
        bscm_req_model u_req (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .start_in(start[g]),
            .cmd_in(cmd[g]),
            .grant_in(grant_out[g]),
            .rsp_in(rsp_w[g]),
            .req_out(req_w[g]),
            .busy_out(busy[g]),
            .rdata_out(rdata[g])
        );
    end

    // ========================================================
    // shared tasks
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got, input logic [63:0] msk);
        checks++;
        if ((got & msk) !== (exp & msk)) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h",
                     what, exp & msk, got & msk);
        end
    endtask : check

    task automatic arm(input int p, input logic wr, input logic fe,
                       input bscm_pkg::bscm_space_t sp,
                       input logic [1:0] blk, input logic [17:0] a,
                       input logic [63:0] wd);
        cmd[p] <= '{1'b1, wr, fe, sp, blk, a, wd};
        start[p] <= 1'b1;
    endtask : arm

    task automatic wait_idle(input int p);
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (busy[p] !== 1'b0 && n < 40);
        if (busy[p] !== 1'b0) begin
            n_mismatch++;
            $display("unexpected timeout on port %0d", p);
            summarize();
        end
    endtask : wait_idle

    // one access on the core data port, waited to completion
    task automatic op(input logic wr, input logic fe,
                      input bscm_pkg::bscm_space_t sp,
                      input logic [1:0] blk, input logic [17:0] a,
                      input logic [63:0] wd);
        @(posedge mclk_in);
        arm(2, wr, fe, sp, blk, a, wd);
        @(posedge mclk_in);
        start <= 4'h0;
        wait_idle(2);
    endtask : op

    // ========================================================
    // scenarios
    task automatic test_reset;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        check("io slot in reset", 64'h0, io_slot_out, 64'h1);
        check("rsp valid in reset", 64'h0, rsp_w[2].valid, 64'h1);
        @(posedge mclk_in);
        #1;
        check("io slot first", 64'h1, io_slot_out, 64'h1);
        @(posedge mclk_in);
        #1;
        check("io slot second", 64'h0, io_slot_out, 64'h1);
        $display("test reset done");
    endtask : test_reset

    task automatic test_alias;
        logic [63:0] d;
        d = 64'hA1B2_C3D4_E5F6_0718;
        @(posedge mclk_in);
        arm(2, 1'b1, 1'b0, bscm_pkg::SP_LONG, 2'h2, 18'h5, d);
        arm(3, 1'b0, 1'b0, bscm_pkg::SP_LONG, 2'h2, 18'h5, 64'h0);
        @(posedge mclk_in);
        start <= 4'h0;
        wait_idle(3);
        check("forwarded long", d, rdata[3], '1);
        for (int k = 0; k < 4; k++) begin
            op(1'b0, 1'b0, bscm_pkg::SP_SHORT, 2'h2, 18'(20 + k), 64'h0);
            check("short", {48'h0, d[16*k +: 16]}, rdata[2], 64'hFFFF);
        end
        for (int j = 0; j < 2; j++) begin
            op(1'b0, 1'b0, bscm_pkg::SP_NORMAL, 2'h2, 18'(10 + j), 64'h0);
            check("normal", {32'h0, d[32*j +: 32]}, rdata[2], 64'hFFFF_FFFF);
        end
        op(1'b1, 1'b0, bscm_pkg::SP_SHORT, 2'h2, 18'h15, 64'h5A5A);
        op(1'b0, 1'b0, bscm_pkg::SP_LONG, 2'h2, 18'h5, 64'h0);
        check("long", {d[63:32], 16'h5A5A, d[15:0]}, rdata[2], '1);
        $display("test alias done");
    endtask : test_alias

    task automatic test_rotation;
        @(posedge mclk_in);
        block_extended_width_bit_in <= 4'h2;
        // second wide word packed after the first; the switch to
        // four-column reads lands on a row boundary
        op(1'b1, 1'b0, bscm_pkg::SP_NORMAL, 2'h1, 18'h1,
           64'hC3_5A96_0F1E);
        op(1'b1, 1'b0, bscm_pkg::SP_NORMAL, 2'h1, 18'h2, 64'h7E_8124_DB96);
        op(1'b0, 1'b0, bscm_pkg::SP_LONG, 2'h1, 18'h1, 64'h0);
        check("rotated row", 64'h24DB_7E81_1E00_960F, rdata[2], '1);
        op(1'b0, 1'b0, bscm_pkg::SP_LONG, 2'h1, 18'h0, 64'h0);
        check("top col", 64'hC35A << 48, rdata[2], 64'hFFFF << 48);
        op(1'b0, 1'b0, bscm_pkg::SP_NORMAL, 2'h1, 18'h1, 64'h0);
        check("ext read", 64'hC3_5A96_0F1E, rdata[2], 64'hFF_FFFF_FFFF);
        op(1'b0, 1'b1, bscm_pkg::SP_NORMAL, 2'h1, 18'h1, 64'h0);
        check("fetch", 64'hC35A_960F_1E00, rdata[2], 64'hFFFF_FFFF_FFFF);
        @(posedge mclk_in);
        block_extended_width_bit_in <= 4'h0;
        // a 32-bit read inside the gap sees the wide words' bits
        op(1'b0, 1'b0, bscm_pkg::SP_NORMAL, 2'h1, 18'h2, 64'h0);
        check("gap alias", 64'h1E00_960F, rdata[2], 64'hFFFF_FFFF);
        op(1'b0, 1'b0, bscm_pkg::SP_NORMAL, 2'h1, 18'h1, 64'h0);
        check("narrow read", 64'hC35A_0000, rdata[2], 64'hFFFF_0000);
        // fetches stay 48 bits wide with the width bit clear
        op(1'b0, 1'b1, bscm_pkg::SP_NORMAL, 2'h1, 18'h1, 64'h0);
        check("fetch narrow", 64'hC35A_960F_1E00, rdata[2],
              64'hFFFF_FFFF_FFFF);
        $display("test rotation done");
    endtask : test_rotation

    task automatic test_arbitration;
        logic [3:0] g_exp [4];
        int         n;
        g_exp = '{4'h1, 4'h4, 4'h2, 4'h8};
        n = 0;
        do begin
            @(posedge mclk_in);
            #1;
            n++;
        end while (io_slot_out !== 1'b1 && n < 4);
        check("io slot align", 64'h1, io_slot_out, 64'h1);
        if (io_slot_out !== 1'b1) begin
            summarize();
        end
        @(posedge mclk_in);
        for (int p = 0; p < 4; p++) begin
            arm(p, 1'b0, 1'b0, bscm_pkg::SP_SHORT, 2'h0, 18'h0, 64'h0);
        end
        @(posedge mclk_in);
        start <= 4'h0;
        for (int i = 0; i < 4; i++) begin
            #1;
            check("grant", {60'h0, g_exp[i]}, {60'h0, grant_out}, 64'hF);
            @(posedge mclk_in);
        end
        wait_idle(3);
        @(posedge mclk_in);
        arm(2, 1'b0, 1'b0, bscm_pkg::SP_SHORT, 2'h0, 18'h0, 64'h0);
        arm(3, 1'b0, 1'b0, bscm_pkg::SP_SHORT, 2'h3, 18'h0, 64'h0);
        @(posedge mclk_in);
        start <= 4'h0;
        #1;
        check("split grant", 64'hC, {60'h0, grant_out}, 64'hF);
        wait_idle(2);
        wait_idle(3);
        $display("test arbitration done");
    endtask : test_arbitration

    // ========================================================
    // clock and main sequence
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    initial begin
        rst_n_in = 1'b0;
        start = 4'h0;
        block_extended_width_bit_in = 4'h0;
        cmd = '{default: '0};
        n_mismatch = 0;
        checks = 0;
        test_reset();
        test_alias();
        test_rotation();
        test_arbitration();
        summarize();
    end
endmodule : testbench
